// ---- hdl/smbus_pec_pkg.sv ----
// Functional notes
// R01: result register holds latest byte CRC
// R02: each byte: compute CRC, load, set ready
// R03: reading CRC result clears ready flag
// R04: hardware clears ready before next load
// R05: baud field divides clock by 20..2560
// R06: software keeps bit rate 10-100 kHz
// R07: arbitration loss releases both lines immediately
// R08: after loss, stay busy until STOP
// R09: disabling releases bus, clears busy flag
// R10: re-enabling resumes normal operation
// R11: software time-out recovers a hung bus
// R12: software copies CRC into transmit holding
// R13: CRC-8, poly 07, zero seed, accumulated
package smbus_pec_pkg;

  // register byte offsets on the slave port
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIV = 8'h04;
  localparam logic [7:0] OFF_CRC = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_ISTAT = 8'h10;
  localparam logic [7:0] OFF_IMASK = 8'h14;

  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b0;

  // divider select field
  localparam int DIV_SEL_W = 3;
  localparam logic [2:0] DIV_SEL_RST = 3'h0;

  // status register fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_STALL_BIT = 2;

  // interrupt status and mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_CRC_BIT = 0;
  localparam int IRQ_ARB_BIT = 1;
  localparam int IRQ_STOP_BIT = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // bit-rate divider: code n divides by base shifted left by n
  localparam int DIV_CNT_W = 12;
  localparam logic [11:0] DIV_BASE = 12'h014;

  // packet error code polynomial and seed
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // one wire pair of the two-wire bus
  typedef struct packed {
    logic sda;
    logic scl;
  } line_pair_t;

  // bus ownership as seen by this block
  typedef enum logic [1:0] {
    LS_IDLE,
    LS_ACTIVE,
    LS_STALLED
  } link_state_t;

endpackage : smbus_pec_pkg

// ---- hdl/pec_crc8_step.sv ----
`timescale 1ns/1ns
`default_nettype none
// one byte of the packet error code, msb first, combinational
module pec_crc8_step (
  // running remainder and new byte
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  // updated remainder
  output logic [7:0] crc_out
);
  // stage k holds the remainder after k data bits
  logic [7:0] stage [0:8];

  assign stage[0] = crc_in;

  // one shift-and-reduce per data bit
  genvar i;
  for (i = 0; i < 8; i++)
  begin : g_bit
    wire logic fb = stage[i][7] ^ data_in[7 - i];
    assign stage[i + 1] = {stage[i][6:0], 1'b0} ^ (fb ? smbus_pec_pkg::CRC_POLY : 8'h00); // R13
  end

  assign crc_out = stage[8];

  // a lone 01 byte from a zero seed leaves the polynomial itself
  property p_r13;
    @(stage[8]) (crc_in == 8'h00 && data_in == 8'h01) |-> crc_out == smbus_pec_pkg::CRC_POLY;
  endproperty
  a_r13: assert property (p_r13) else $error("crc step wrong for unit byte"); // R13
endmodule : pec_crc8_step
`default_nettype wire

// ---- hdl/bit_rate_divider.sv ----
`timescale 1ns/1ns
`default_nettype none
// divides the bus clock into one tick per serial bit period
module bit_rate_divider #(
  parameter int CNT_W = smbus_pec_pkg::DIV_CNT_W
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic enable,
  input wire logic [2:0] sel,
  // one-cycle tick per bit period
  output logic tick
);
  logic [CNT_W-1:0] cnt_r;
  logic tick_r;
  // terminal count: base shifted by the code, minus one
  wire logic [CNT_W-1:0] limit = CNT_W'((smbus_pec_pkg::DIV_BASE << sel) - 12'h001); // R05
  wire logic wrap = (cnt_r >= limit);

  // counter restarts when disabled so the first period is whole
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= (!enable || wrap) ? '0 : cnt_r + 1'b1; // R05
      tick_r <= enable && wrap;
    end
  end

  assign tick = tick_r;

  property p_r05;
    @(posedge hclk) disable iff (!hresetn)
      (enable && cnt_r == limit && $stable(sel)) |=> (tick_r && cnt_r == '0);
  endproperty
  a_r05: assert property (p_r05) else $error("baud tick not at terminal count"); // R05
endmodule : bit_rate_divider
`default_nettype wire

// ---- hdl/smbus_pec_crc_and_baud_divider.sv ----
`timescale 1ns/1ns
`default_nettype none
// packet error code, bit-rate divider and hang recovery for the two-wire unit
module smbus_pec_crc_and_baud_divider (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // rest of the two-wire unit, same clock
  input wire logic byte_done,
  input wire logic [7:0] byte_data,
  input wire logic master_active,
  input wire logic arb_lost,
  input wire smbus_pec_pkg::line_pair_t drive_low_req,
  output logic module_enable,
  output logic bus_busy_flag,
  output logic baud_tick,
  // bus pins, open drain
  input wire smbus_pec_pkg::line_pair_t line_in,
  output smbus_pec_pkg::line_pair_t line_out,
  output smbus_pec_pkg::line_pair_t line_oe,
  // interrupt
  output logic irq
);

  // slave port state
  logic pend_r; // data phase in progress
  logic ap_write_r; // captured direction
  logic [7:0] ap_addr_r; // captured low address byte
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic hresp_r;

  // software-visible registers
  logic enable_r;
  logic [2:0] div_sel_r;
  logic [7:0] pec_result_r;
  logic crc_ready_r;
  logic [2:0] istat_r;
  logic [2:0] imask_r;

  // crc datapath
  logic [7:0] crc_acc_r; // running remainder of the message
  logic load_pend_r; // result loads on the cycle after a byte
  logic [7:0] crc_next;

  // pin synchronisers and history
  smbus_pec_pkg::line_pair_t sync1_r;
  smbus_pec_pkg::line_pair_t sync2_r;
  smbus_pec_pkg::line_pair_t hist_r;

  // bus ownership
  smbus_pec_pkg::link_state_t state_r;
  smbus_pec_pkg::link_state_t state_nxt;

  // registered outputs
  smbus_pec_pkg::line_pair_t line_oe_r;
  smbus_pec_pkg::line_pair_t line_oe_nxt;
  smbus_pec_pkg::line_pair_t line_out_r;
  logic busy_r;
  logic irq_r;

  // address phase accepted; hready is our own hreadyout
  wire logic take = hsel && hready && htrans[1];

  // register strobes in the data phase
  wire logic wr = pend_r && ap_write_r;
  wire logic rd = pend_r && !ap_write_r;
  wire logic wr_ctrl = wr && (ap_addr_r == smbus_pec_pkg::OFF_CTRL);
  wire logic wr_div = wr && (ap_addr_r == smbus_pec_pkg::OFF_DIV);
  wire logic wr_istat = wr && (ap_addr_r == smbus_pec_pkg::OFF_ISTAT);
  wire logic wr_imask = wr && (ap_addr_r == smbus_pec_pkg::OFF_IMASK);
  wire logic rd_crc = rd && (ap_addr_r == smbus_pec_pkg::OFF_CRC);

  // status word assembled from live state
  wire logic [31:0] stat_word = 32'((crc_ready_r << smbus_pec_pkg::STAT_READY_BIT)
    | (busy_r << smbus_pec_pkg::STAT_BUSY_BIT)
    | ((state_r == smbus_pec_pkg::LS_STALLED) << smbus_pec_pkg::STAT_STALL_BIT));

  // read mux; unmapped offsets read zero
  wire logic [31:0] rd_mux =
    (ap_addr_r == smbus_pec_pkg::OFF_CTRL) ? {31'h0, enable_r} :
    (ap_addr_r == smbus_pec_pkg::OFF_DIV) ? {29'h0, div_sel_r} :
    (ap_addr_r == smbus_pec_pkg::OFF_CRC) ? {24'h0, pec_result_r} :
    (ap_addr_r == smbus_pec_pkg::OFF_STAT) ? stat_word :
    (ap_addr_r == smbus_pec_pkg::OFF_ISTAT) ? {29'h0, istat_r} :
    (ap_addr_r == smbus_pec_pkg::OFF_IMASK) ? {29'h0, imask_r} : 32'h0;

  // start and stop seen on synchronised lines while scl is high
  wire logic start_seen = sync2_r.scl && hist_r.scl && hist_r.sda && !sync2_r.sda;
  wire logic stop_seen = sync2_r.scl && hist_r.scl && !hist_r.sda && sync2_r.sda;

  // events from the rest of the unit, gated by the enable
  wire logic byte_go = byte_done && enable_r;
  wire logic arb_go = arb_lost && master_active && enable_r;

  // interrupt status: set wins over the write-one clear
  wire logic [2:0] ievents = {stop_seen, arb_go, load_pend_r};
  wire logic [2:0] istat_nxt = (istat_r & ~(wr_istat ? hwdata[2:0] : 3'h0)) | ievents;

  // the result load sets the flag even if a read clears it that cycle
  wire logic crc_ready_nxt = load_pend_r ? 1'b1 // R02
    : (byte_go || rd_crc) ? 1'b0 // R03 R04
    : crc_ready_r;

  // message boundary or disable restarts the remainder
  wire logic crc_restart = start_seen || stop_seen || !enable_r;

  // crc of the running remainder and the finished byte
  pec_crc8_step u_crc (
    .crc_in (crc_acc_r),
    .data_in (byte_data),
    .crc_out (crc_next)
  );

  // bit period generator, idle while the module is off
  bit_rate_divider #(
    .CNT_W (smbus_pec_pkg::DIV_CNT_W)
  ) u_div (
    .hclk (hclk),
    .hresetn (hresetn),
    .enable (enable_r),
    .sel (div_sel_r),
    .tick (baud_tick)
  );

  // slave handshake: every transfer gets exactly one wait state,
  // so read data always comes from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h0;
      hresp_r <= 1'b0;
    end
    else
    begin
      pend_r <= take;
      hreadyout_r <= !take;
      hresp_r <= 1'b0;
      if (take)
      begin
        ap_write_r <= hwrite;
        ap_addr_r <= haddr[7:0];
      end
      if (rd)
        hrdata_r <= rd_mux;
    end
  end

  // software control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable_r <= smbus_pec_pkg::CTRL_EN_RST;
      div_sel_r <= smbus_pec_pkg::DIV_SEL_RST;
      imask_r <= smbus_pec_pkg::IRQ_RST;
      istat_r <= smbus_pec_pkg::IRQ_RST;
    end
    else
    begin
      // clearing the enable is the software escape from a hung bus
      if (wr_ctrl)
        enable_r <= hwdata[smbus_pec_pkg::CTRL_EN_BIT]; // R09 R10
      if (wr_div)
        div_sel_r <= hwdata[smbus_pec_pkg::DIV_SEL_W-1:0]; // R05
      if (wr_imask)
        imask_r <= hwdata[smbus_pec_pkg::IRQ_W-1:0];
      istat_r <= istat_nxt;
    end
  end

  // crc: remainder on the byte, result and flag one cycle later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      crc_acc_r <= smbus_pec_pkg::CRC_INIT;
      load_pend_r <= 1'b0;
      pec_result_r <= smbus_pec_pkg::CRC_INIT;
      crc_ready_r <= 1'b0;
    end
    else
    begin
      if (byte_go)
        crc_acc_r <= crc_next; // R13
      else if (crc_restart)
        crc_acc_r <= smbus_pec_pkg::CRC_INIT; // R13
      load_pend_r <= byte_go;
      if (load_pend_r)
        pec_result_r <= crc_acc_r; // R01 R02
      crc_ready_r <= crc_ready_nxt;
    end
  end

  // pin synchronisers; only the second stage and its history copy feed logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
      hist_r <= '1;
    end
    else
    begin
      sync1_r <= line_in;
      sync2_r <= sync1_r;
      hist_r <= sync2_r;
    end
  end

  // ownership: a lost arbitration parks here until a stop or a disable,
  // because the shifter cannot tell where the frame ends
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      smbus_pec_pkg::LS_IDLE:
      begin
        if (arb_go)
          state_nxt = smbus_pec_pkg::LS_STALLED;
        else if (start_seen)
          state_nxt = smbus_pec_pkg::LS_ACTIVE;
      end
      smbus_pec_pkg::LS_ACTIVE:
      begin
        if (arb_go)
          state_nxt = smbus_pec_pkg::LS_STALLED; // R08
        else if (stop_seen)
          state_nxt = smbus_pec_pkg::LS_IDLE;
      end
      smbus_pec_pkg::LS_STALLED:
      begin
        // only a stop or a disable ends the stall; no timer here
        if (stop_seen)
          state_nxt = smbus_pec_pkg::LS_IDLE; // R08
      end
      default:
        state_nxt = smbus_pec_pkg::LS_IDLE;
    endcase
    // disable overrides everything
    if (!enable_r)
      state_nxt = smbus_pec_pkg::LS_IDLE; // R09
  end

  // drive only while enabled, not stalled and not losing this cycle
  always_comb
  begin
    line_oe_nxt = drive_low_req;
    if (!enable_r || arb_go || state_nxt == smbus_pec_pkg::LS_STALLED)
      line_oe_nxt = '0; // R07 R09
  end

  // registered outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= smbus_pec_pkg::LS_IDLE;
      line_oe_r <= '0;
      line_out_r <= '0;
      busy_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      line_oe_r <= line_oe_nxt;
      line_out_r <= '0;
      busy_r <= (state_nxt != smbus_pec_pkg::LS_IDLE); // R08 R09
      irq_r <= |(istat_nxt & imask_r);
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign module_enable = enable_r;
  assign bus_busy_flag = busy_r;
  assign line_out = line_out_r;
  assign line_oe = line_oe_r;
  assign irq = irq_r;

  // checks
  property p_r01;
    @(posedge hclk) disable iff (!hresetn)
      load_pend_r |=> (crc_ready_r && pec_result_r == $past(crc_acc_r));
  endproperty
  a_r01: assert property (p_r01) else $error("result not the byte crc"); // R01

  property p_r02;
    @(posedge hclk) disable iff (!hresetn)
      byte_go |=> load_pend_r ##1 crc_ready_r;
  endproperty
  a_r02: assert property (p_r02) else $error("ready not set two cycles after byte"); // R02

  property p_r03;
    @(posedge hclk) disable iff (!hresetn)
      (rd_crc && !load_pend_r) |=> !crc_ready_r;
  endproperty
  a_r03: assert property (p_r03) else $error("crc read left ready set"); // R03

  property p_r04;
    @(posedge hclk) disable iff (!hresetn)
      (byte_go && !load_pend_r) |=> !crc_ready_r;
  endproperty
  a_r04: assert property (p_r04) else $error("ready not cleared before load"); // R04

  property p_r07;
    @(posedge hclk) disable iff (!hresetn)
      arb_go |=> (line_oe == '0) [*2];
  endproperty
  a_r07: assert property (p_r07) else $error("line still driven after loss"); // R07

  property p_r08;
    @(posedge hclk) disable iff (!hresetn)
      (state_r == smbus_pec_pkg::LS_STALLED && !stop_seen && enable_r)
        |=> (state_r == smbus_pec_pkg::LS_STALLED && bus_busy_flag);
  endproperty
  a_r08: assert property (p_r08) else $error("stall left without stop"); // R08

  property p_r09;
    @(posedge hclk) disable iff (!hresetn)
      !enable_r |=> (!bus_busy_flag && line_oe == '0 && state_r == smbus_pec_pkg::LS_IDLE);
  endproperty
  a_r09: assert property (p_r09) else $error("disable did not release bus"); // R09

  property p_r10;
    @(posedge hclk) disable iff (!hresetn)
      (enable_r && start_seen && !arb_go) |=> bus_busy_flag;
  endproperty
  a_r10: assert property (p_r10) else $error("enabled block missed a start"); // R10

  c_crc: cover property (@(posedge hclk) disable iff (!hresetn) byte_go ##2 rd_crc);
  c_stall: cover property (@(posedge hclk) disable iff (!hresetn)
    state_r == smbus_pec_pkg::LS_STALLED ##[1:50] stop_seen);
  c_recover: cover property (@(posedge hclk) disable iff (!hresetn)
    state_r == smbus_pec_pkg::LS_STALLED ##1 !enable_r ##[1:20] enable_r);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq_r));

endmodule : smbus_pec_crc_and_baud_divider
`default_nettype wire

// ---- verif/bus_peer_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// another master on the two-wire bus: open-drain pair with pull-ups
module bus_peer_model (
  // clock used only to pace the frame edges
  input wire logic hclk,
  // pull-down enables of the block under test
  input wire smbus_pec_pkg::line_pair_t dut_oe,
  // resolved wire levels seen by everyone
  output var smbus_pec_pkg::line_pair_t line_in
);
  // high bit = this peer pulls that line low
  smbus_pec_pkg::line_pair_t pull_r = 2'h0;

  // wired-and: a released line floats back high through its pull-up
  assign line_in = ~(dut_oe | pull_r);

  // start: data falls while clock is high, then clock is held low
  task gen_start;
    pull_r.sda <= 1'b1;
    repeat (8) @(posedge hclk);
    pull_r.scl <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : gen_start

  // stop: data low, clock released, then data rises with clock high
  task gen_stop;
    pull_r.sda <= 1'b1;
    repeat (8) @(posedge hclk);
    pull_r.scl <= 1'b0;
    repeat (8) @(posedge hclk);
    pull_r.sda <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : gen_stop
endmodule : bus_peer_model
`default_nettype wire

// ---- verif/tb_smbus_pec_crc_and_baud_divider.sv ----
`timescale 1ns/1ns
`default_nettype none
// register-level test of the pec, divider and hang recovery block
module tb_smbus_pec_crc_and_baud_divider;
  // bus master side
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  // shifter side of the unit
  logic byte_done = 1'b0;
  logic [7:0] byte_data = 8'h0;
  logic master_active = 1'b0;
  logic arb_lost = 1'b0;
  smbus_pec_pkg::line_pair_t drive_low_req = 2'h0;
  wire logic module_enable;
  wire logic bus_busy_flag;
  wire logic baud_tick;
  wire logic irq;
  // wire pair
  smbus_pec_pkg::line_pair_t line_in;
  smbus_pec_pkg::line_pair_t line_out;
  smbus_pec_pkg::line_pair_t line_oe;
  // bookkeeping
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  logic [31:0] rd;
  logic [7:0] crc;

  // 4 ns clock
  always #2 hclk = ~hclk;

  smbus_pec_crc_and_baud_divider i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .byte_done(byte_done),
    .byte_data(byte_data), .master_active(master_active), .arb_lost(arb_lost),
    .drive_low_req(drive_low_req), .module_enable(module_enable),
    .bus_busy_flag(bus_busy_flag), .baud_tick(baud_tick), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .irq(irq)
  );

  bus_peer_model i_peer (.hclk(hclk), .dut_oe(line_oe), .line_in(line_in));

  // compare and count
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one single transfer; entered just after a rising edge
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("response", {31'h0, hresp}, 32'h0);
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rd_chk

  // one byte from the shifter, spaced well past the two-cycle minimum
  task send(input logic [7:0] b);
    byte_data <= b;
    byte_done <= 1'b1;
    @(posedge hclk);
    byte_done <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : send

  // independent reference remainder, msb first
  function logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction : crc8

  // cycles between two divider ticks
  task tick_gap(output int g);
    g = 0;
    do @(posedge hclk); while (baud_tick !== 1'b1);
    do
    begin
      @(posedge hclk);
      g++;
    end
    while (baud_tick !== 1'b1);
  endtask : tick_gap

  // counts and verdict
  task wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // hang guard, well above the divider sweep
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, unmapped and read-only places
    for (int i = 0; i < 7; i++)
      rd_chk("reset value", 8'(i * 4), 32'h0);
    wr(8'h18, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h18, 32'h0);
    wr(8'h08, 32'h000000FF);
    rd_chk("crc read only", 8'h08, 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    rd_chk("divider field", 8'h04, 32'h7);
    $display("test registers done");
    // bytes are ignored while disabled
    wr(8'h14, 32'h1);
    send(8'h55);
    rd_chk("stat disabled", 8'h0C, 32'h0);
    wr(8'h00, 32'h1);
    i_peer.gen_start();
    crc = crc8(8'h00, 8'hA5);
    send(8'hA5);
    check("irq on load", {31'h0, irq}, 32'h1);
    rd_chk("ready set", 8'h0C, 32'h3);
    rd_chk("crc first", 8'h08, {24'h0, crc});
    rd_chk("ready cleared", 8'h0C, 32'h2);
    // two bytes without a read in between
    crc = crc8(crc, 8'h3C);
    send(8'h3C);
    crc = crc8(crc, 8'h7E);
    send(8'h7E);
    rd_chk("ready reloaded", 8'h0C, 32'h3);
    rd_chk("crc accumulated", 8'h08, {24'h0, crc});
    wr(8'h10, 32'h1);
    repeat (2) @(posedge hclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(8'h14, 32'h0);
    send(8'h11);
    check("irq masked", {31'h0, irq}, 32'h0);
    rd_chk("istat", 8'h10, 32'h1);
    // a new message restarts the remainder from zero
    i_peer.gen_stop();
    i_peer.gen_start();
    send(8'h01);
    rd_chk("crc restart", 8'h08, {24'h0, crc8(8'h00, 8'h01)});
    // software sends the ready crc as the closing pec byte; the remainder then folds to zero
    send(rd[7:0]);
    rd_chk("pec residue", 8'h08, 32'h0);
    i_peer.gen_stop();
    wr(8'h10, 32'h7);
    $display("test crc done");
    // every divider code; the loop ends on the slowest, in range at this clock
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h04, 32'(s));
      tick_gap(n);
      tick_gap(n);
      check("tick spacing", 32'(n), 32'(20 << s));
    end
    $display("test divider done");
    // arbitration loss, then stall until stop
    i_peer.gen_start();
    master_active <= 1'b1;
    drive_low_req <= 2'h3;
    repeat (3) @(posedge hclk);
    check("driving", {30'h0, line_oe}, 32'h3);
    check("open drain level", {30'h0, line_out}, 32'h0);
    arb_lost <= 1'b1;
    @(posedge hclk);
    arb_lost <= 1'b0;
    @(posedge hclk);
    check("released", {30'h0, line_oe}, 32'h0);
    repeat (40) @(posedge hclk);
    rd_chk("stalled", 8'h0C, 32'h6);
    check("still released", {30'h0, line_oe}, 32'h0);
    drive_low_req <= 2'h0;
    i_peer.gen_stop();
    check("busy after stop", {31'h0, bus_busy_flag}, 32'h0);
    rd_chk("events", 8'h10, 32'h6);
    // no stop ever comes: software time-out disables the unit
    i_peer.gen_start();
    drive_low_req <= 2'h3;
    arb_lost <= 1'b1;
    @(posedge hclk);
    arb_lost <= 1'b0;
    repeat (10) @(posedge hclk);
    wr(8'h00, 32'h0);
    // the flag follows the enable one edge later, so let that edge pass
    @(posedge hclk);
    check("enable out off", {31'h0, module_enable}, 32'h0);
    check("busy after disable", {31'h0, bus_busy_flag}, 32'h0);
    check("lines after disable", {30'h0, line_oe}, 32'h0);
    drive_low_req <= 2'h0;
    i_peer.gen_stop();
    wr(8'h00, 32'h1);
    i_peer.gen_start();
    drive_low_req <= 2'h3;
    repeat (3) @(posedge hclk);
    check("drives again", {30'h0, line_oe}, 32'h3);
    check("enable out on", {31'h0, module_enable}, 32'h1);
    check("busy again", {31'h0, bus_busy_flag}, 32'h1);
    drive_low_req <= 2'h0;
    master_active <= 1'b0;
    i_peer.gen_stop();
    $display("test recovery done");
    wrap_up();
  end
endmodule : tb_smbus_pec_crc_and_baud_divider
`default_nettype wire
